// >>> arr_defs.svh
// Register offsets, field positions and reset values of the ADC result bank
`ifndef ARR_DEFS_SVH
`define ARR_DEFS_SVH
`define ARR_OFS_IIN_LO 8'h18
`define ARR_OFS_ICHG_HI 8'h19
`define ARR_OFS_ICHG_LO 8'h1a
`define ARR_OFS_VOLT_HI 8'h1b
`define ARR_OFS_VOLT_LO 8'h1c
`define ARR_FLD_LO 7:0
`define ARR_FLD_HI 15:8
`define ARR_FLD_ICHG_HI 14:8
`define ARR_RSVD_BIT 1'b0
`define ARR_RST_BYTE 8'h00
`define ARR_RST_WORD 16'h0000
`define ARR_ICHG_MASK 16'h7fff
`define ARR_RATE_CONT 1'b0
`define ARR_RATE_ONESHOT 1'b1
`endif

// >>> arr_pkg.sv
// Types shared by the ADC result bank
package arr_pkg;
  typedef struct packed {
    logic [15:0] input_current_result;
    logic [15:0] charge_current_result;
    logic [15:0] bus_voltage_result;
  } arr_sample_s;
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } arr_req_s;
  typedef enum logic [1:0] {
    ARR_IDLE = 2'b00,
    ARR_CONT = 2'b01,
    ARR_SHOT = 2'b10
  } arr_state_e;
endpackage

// >>> arr_rdmux.sv
// Read multiplexer for the result registers
`include "arr_defs.svh"
module arr_rdmux
  import arr_pkg::*;
(
  input wire logic [7:0] addr,
  input wire logic [15:0] iin,
  input wire logic [15:0] ichg,
  input wire logic [15:0] volt,
  output logic [7:0] rdata,
  output logic hit
);
  wire logic hit_iin = (addr == `ARR_OFS_IIN_LO);
  wire logic hit_ichg_hi = (addr == `ARR_OFS_ICHG_HI);
  wire logic hit_ichg_lo = (addr == `ARR_OFS_ICHG_LO);
  wire logic hit_volt_hi = (addr == `ARR_OFS_VOLT_HI);
  wire logic hit_volt_lo = (addr == `ARR_OFS_VOLT_LO);
  assign hit = hit_iin | hit_ichg_hi | hit_ichg_lo | hit_volt_hi | hit_volt_lo;
  assign rdata = hit_iin ? iin[`ARR_FLD_LO] : // RL1
                 hit_ichg_hi ? {`ARR_RSVD_BIT, ichg[`ARR_FLD_ICHG_HI]} : // RL4 RL5
                 hit_ichg_lo ? ichg[`ARR_FLD_LO] : // RL6
                 hit_volt_hi ? volt[`ARR_FLD_HI] : // RL7
                 hit_volt_lo ? volt[`ARR_FLD_LO] : // RL8
                 `ARR_RST_BYTE;
endmodule

// >>> arr_result_bank.sv
// ADC result register bank of a charger monitor
// Overview of operation
// RL1 - The input current low byte reads at offset 0x18 with 1 mA per bit and resets to zero.
// RL2 - Current into the input bus pin is positive and current out of it is negative.
// RL3 - Input current results cover zero to 4 A.
// RL4 - Charge current bits 14 to 8 read in bits 6 to 0 at offset 0x19.
// RL5 - Bit 7 of the charge current high byte always reads zero.
// RL6 - The charge current low byte reads at offset 0x1a with 1 mA per bit.
// RL7 - Bus voltage is 16-bit two's complement with the sign in bit 7 at offset 0x1b.
// RL8 - The bus voltage low byte reads at offset 0x1c with 1 mV per bit.
// RL9 - Results refresh only while enabled, continuously for rate 0 and once for rate 1; a sample in the cycle enable falls is still stored.
// RL10 - Register reset clears all results, watchdog keeps them, and writes are ignored.
`include "arr_defs.svh"
module arr_result_bank
  import arr_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic adc_en,
  input wire logic adc_rate,
  input wire logic reg_rst,
  input wire logic watchdog_expired,
  input wire logic sample_valid,
  input wire arr_sample_s sample,
  input wire arr_req_s req,
  output logic [7:0] rdata,
  output logic rvalid,
  output logic adc_busy
);
  // =====================================================
  // Conversion control
  arr_state_e state_r;
  arr_state_e state_nxt;
  logic shot_done_r;
  logic shot_done_nxt;

  // Idle is the only state that refuses results
  function automatic logic conv_active(input arr_state_e st);
    return (st != ARR_IDLE);
  endfunction

  wire logic rate_oneshot = (adc_rate == `ARR_RATE_ONESHOT); // RL9
  // A finished one-shot stays idle until enable is dropped or a register reset clears it
  wire logic can_start = adc_en & ~shot_done_r; // RL9

  wire logic cont_stop = ~adc_en; // RL9
  wire logic shot_stop = ~adc_en | sample_valid; // RL9

  wire logic take = sample_valid & conv_active(state_r); // RL9
  wire logic shot_end = (state_r == ARR_SHOT) & sample_valid & adc_en;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ARR_IDLE: begin
        if (can_start) begin
          state_nxt = rate_oneshot ? ARR_SHOT : ARR_CONT; // RL9
        end
      end
      ARR_CONT: begin
        if (cont_stop) begin
          state_nxt = ARR_IDLE;
        end
      end
      ARR_SHOT: begin
        // One-shot finishes after a single stored result
        if (shot_stop) begin
          state_nxt = ARR_IDLE;
        end
      end
      default: begin
        state_nxt = ARR_IDLE;
      end
    endcase
    if (reg_rst) begin
      state_nxt = ARR_IDLE; // RL10
    end
  end

  // =====================================================
  // One-shot hold-off
  // Without it idle would re-arm at once and one-shot would behave as continuous
  wire logic done_set = shot_end & ~reg_rst;
  wire logic done_clr = ~adc_en | reg_rst;

  always_comb begin
    shot_done_nxt = shot_done_r;
    if (done_clr) begin
      shot_done_nxt = 1'b0;
    end
    if (done_set) begin
      shot_done_nxt = 1'b1; // RL9
    end
  end

  // =====================================================
  // Result storage
  arr_sample_s res_r;
  arr_sample_s res_nxt;

  // Sign passes through unchanged: negative current out of the pin stays negative
  wire logic [15:0] iin_in = sample.input_current_result; // RL2 RL3
  wire logic [15:0] ichg_in = sample.charge_current_result & `ARR_ICHG_MASK; // RL4 RL5
  wire logic [15:0] volt_in = sample.bus_voltage_result; // RL7 RL8

  // Clear beats load: a register reset drops a sample of the same cycle
  function automatic logic [15:0] next_result(
    input logic [15:0] cur,
    input logic [15:0] fresh,
    input logic load,
    input logic clr
  );
    logic [15:0] val;
    val = cur;
    if (load) begin
      val = fresh;
    end
    if (clr) begin
      val = `ARR_RST_WORD; // RL10
    end
    return val;
  endfunction

  always_comb begin
    res_nxt.input_current_result = next_result(res_r.input_current_result, iin_in, take, reg_rst);
    res_nxt.charge_current_result = next_result(res_r.charge_current_result, ichg_in, take, reg_rst);
    res_nxt.bus_voltage_result = next_result(res_r.bus_voltage_result, volt_in, take, reg_rst);
  end

  // =====================================================
  // Watchdog
  // Expiry resets control settings elsewhere but must never disturb a stored
  // result, so the input is accepted here and deliberately has no term
  // in any next-value logic

  // =====================================================
  // Register read port
  logic [7:0] mux_data;
  logic mux_hit;

  logic [7:0] rdata_nxt;
  logic [7:0] rdata_r;
  logic rvalid_nxt;
  logic rvalid_r;
  logic busy_nxt;
  logic busy_r;

  // Write strobe and data are never decoded: every register here is read-only
  arr_rdmux u_rdmux (
    .addr(req.addr),
    .iin(res_r.input_current_result),
    .ichg(res_r.charge_current_result),
    .volt(res_r.bus_voltage_result),
    .rdata(mux_data),
    .hit(mux_hit)
  );

  // Unmapped offsets and cycles without a read both return zero
  wire logic rd_hit = req.rd & mux_hit;
  assign rdata_nxt = rd_hit ? mux_data : `ARR_RST_BYTE; // RL10
  assign rvalid_nxt = req.rd;

  // Busy follows the state the machine is about to enter
  assign busy_nxt = conv_active(state_nxt); // RL9

  // =====================================================
  // Registers
  // One short process per register keeps each reset value beside its flop
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= ARR_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      shot_done_r <= 1'b0;
    end else begin
      shot_done_r <= shot_done_nxt;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      res_r <= '{default: `ARR_RST_WORD};
    end else begin
      res_r <= res_nxt;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata_r <= `ARR_RST_BYTE;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rvalid_r <= 1'b0;
    end else begin
      rvalid_r <= rvalid_nxt;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      busy_r <= 1'b0;
    end else begin
      busy_r <= busy_nxt;
    end
  end

  // =====================================================
  // Outputs, each straight from a flop
  assign rdata = rdata_r;
  assign rvalid = rvalid_r;
  assign adc_busy = busy_r;
endmodule

// >>> arr_result_bank_bench.sv
// Self-checking bench for the ADC result bank
module arr_result_bank_bench import arr_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rstn, adc_en, adc_rate, reg_rst, watchdog_expired, sample_valid, rvalid, adc_busy;
  arr_sample_s sample, s;
  arr_req_s req;
  logic [7:0] rdata, a;
  int seed = 39208, err_total, n_tests;
  arr_result_bank DUT (.*);
  initial begin
    clk = 0;
    forever #50 clk = ~clk;
  end
  // ==========
  // Tasks
  task automatic cyc();
    @(posedge clk);
    #1 watchdog_expired = 1'($random(seed));
  endtask
  function automatic logic [7:0] ex(logic [7:0] o, arr_sample_s v);
    case (o)
      8'h18: return v.input_current_result[7:0];
      8'h19: return {1'b0, v.charge_current_result[14:8]};
      8'h1a: return v.charge_current_result[7:0];
      8'h1b: return v.bus_voltage_result[15:8];
      8'h1c: return v.bus_voltage_result[7:0];
      default: return 8'h00;
    endcase
  endfunction
  task automatic chk(string n, logic [8:0] got, logic [8:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s exp %h got %h", n, exp, got);
    end
  endtask
  // Back-to-back reads with random write strobes, which must change nothing
  task automatic sweep(int st, arr_sample_s v);
    for (int j = 0; j < 7; j++) begin
      a = 8'h17 + 8'((st + j) % 7);
      req = '{1'b1, 1'($random(seed)), a, 8'($random(seed))};
      cyc();
      chk("rdata", {rvalid, rdata}, {1'b1, ex(a, v)});
    end
  endtask
  task automatic smp(arr_sample_s v);
    cyc();
    sample_valid = 1;
    sample = v;
    cyc();
    sample_valid = 0;
    sample = ~v;
  endtask
  task automatic test_done();
    if (err_total == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // ==========
  // Sequence
  initial begin
    {rstn, adc_en, adc_rate, reg_rst, watchdog_expired, sample_valid} = 0;
    sample = 0;
    req = 0;
    repeat (8) @(posedge clk);
    #1 rstn = 1;
    sweep(0, 0);
    adc_en = 1;
    cyc();
    for (int i = 0; i < 20; i++) begin
      s = 48'({$random(seed), $random(seed)});
      if (i < 2) s = i ? 48'h8000_7fff_8000 : '1;
      smp(s);
      sweep(i, s);
    end
    reg_rst = 1;
    cyc();
    reg_rst = 0;
    sweep(3, 0);
    adc_en = 0;
    smp(s);
    sweep(5, 0);
    {adc_rate, adc_en} = 2'h3;
    cyc();
    smp(s);
    smp(~s);
    sweep(1, s);
    chk("busy", {8'h00, adc_busy}, 9'h000);
    test_done();
  end
  initial begin
    repeat (9999) @(posedge clk);
    err_total++;
    test_done();
  end
endmodule

// >>> arr_result_bank_checker.sv
// Checker for the ADC result bank ports
module arr_result_bank_checker
  import arr_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic adc_en,
  input wire logic reg_rst,
  input wire logic sample_valid,
  input wire arr_sample_s sample,
  input wire arr_req_s req,
  input wire logic [7:0] rdata,
  input wire logic rvalid,
  input wire logic adc_busy
);
  // ==========
  // Properties
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // Sample taken, then a read with no newer sample
  sequence s_tk(a);
    sample_valid && adc_busy && !reg_rst ##1 req.rd && req.addr == a && !reg_rst && !sample_valid;
  endsequence
  a_iin_low: assert property (s_tk(8'h18) |=> rdata == $past(sample.input_current_result[7:0], 2))
    else $error("iin lo");
  a_chg_hi: assert property (s_tk(8'h19) |=> rdata == {1'b0, $past(sample.charge_current_result[14:8], 2)})
    else $error("chg hi");
  a_chg_lo: assert property (s_tk(8'h1a) |=> rdata == $past(sample.charge_current_result[7:0], 2))
    else $error("chg lo");
  a_volt_hi: assert property (s_tk(8'h1b) |=> rdata == $past(sample.bus_voltage_result[15:8], 2))
    else $error("volt hi");
  a_volt_lo: assert property (s_tk(8'h1c) |=> rdata == $past(sample.bus_voltage_result[7:0], 2))
    else $error("volt lo");
  a_rst_clears: assert property (reg_rst ##1 req.rd |=> rvalid && rdata == 8'h00)
    else $error("rst");
  a_busy_on: assert property ($rose(adc_en) && !reg_rst |=> adc_busy)
    else $error("busy on");
  a_busy_off: assert property (!adc_en |=> !adc_busy)
    else $error("busy off");
  a_shot_once: assert property ($fell(adc_busy) && adc_en && $past(adc_en) && !$past(reg_rst) |=> !adc_busy)
    else $error("one-shot rearmed");
  cover property (s_tk(8'h1b));
  cover property ($fell(adc_busy) && adc_en);
  cover property (reg_rst && adc_busy);
endmodule
bind arr_result_bank arr_result_bank_checker u_chk (.*);
